// >>> common/status_responder_defs.vh
/*
 * constants of the drive status query responder: command codes, frame
 * layout, motion status bit positions, transfer-error bit positions and
 * the register map reached over axi4-lite.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef STATUS_RESPONDER_DEFS_VH
`define STATUS_RESPONDER_DEFS_VH

// command codes
`define CMD_GSTAT        8'h10
`define CMD_ERRSTAT      8'h11
`define CMD_STAT         8'h12
`define CMD_RESET        8'h21
`define CMD_START        8'h31
`define CMD_STOP         8'h32
`define CMD_VSET         8'h41
`define CMD_PSET         8'h43
`define CMD_DSET         8'h44
`define ADDR_GLOBAL      8'hff

// motion status bit positions (16-bit word, high byte at 15:8)
`define MS_VEL_READY     1
`define MS_POS_READY     2
`define MS_ALWAYS_ONE    4
`define MS_NOT_AT_END    5
`define MS_VEL_RUN       6
`define MS_POS_RUN       7
`define MS_JOG           9
`define MS_DECEL         10
`define MS_RSVD0         0
`define MS_RSVD3         3
`define MS_RESET         8'h16

// transfer-error bit positions (16-bit word)
`define TE_FRAMING       0
`define TE_CHECKSUM      2
`define TE_COUNT         4
`define TE_BADCMD        9
`define TE_FAULT         6

// answer lengths in bytes, address through checksum
`define LEN_GSTAT        5'd16
`define LEN_ERRSTAT      5'd7
`define LEN_STAT         5'd14
`define LEN_PLAIN        5'd5
`define LEN_MAX          5'd16

// received frame lengths in bytes, address through checksum
`define FRAME_LEN_VSET   4'd7
`define FRAME_LEN_PSET   4'd9
`define FRAME_LEN_PLAIN  4'd3

// register byte offsets
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_POSITION     8'h08
`define REG_VEL_TEMP     8'h0c
`define REG_FAULT        8'h10
`define REG_DEV_ADDR     8'h14
`define REG_RX           8'h18
`define REG_TX           8'h1c

// control register bit positions
`define CTRL_END_REACHED 0
`define CTRL_DECEL       1
`define CTRL_JOG         2
`define CTRL_RX_ERR      3

// reset value of the device address
`define DEV_ADDR_RESET   8'h01
`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10

`endif

// >>> core/frame_checksum.v
/*
 * running exclusive-or checksum of frame bytes.
 * assumes clear and add are pulses from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module frame_checksum (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clear,
  input  wire       add,
  input  wire [7:0] data,
  output wire [7:0] sum
);
  reg [7:0] sum_q; // running xor of bytes since clear

  // accumulate xor; clear restarts the frame
  always @(posedge aclk) begin
    if (!aresetn) begin
      sum_q <= 8'h00;
    end else if (clear) begin
      sum_q <= 8'h00;
    end else if (add) begin
      sum_q <= sum_q ^ data;
    end
  end

  assign sum = sum_q;
endmodule
`default_nettype wire

// >>> core/axil_slave.v
/*
 * axi4-lite slave front end: accepts one write and one read at a time,
 * hands single-cycle strobes to the register file and returns responses.
 * assumes the register file answers reads combinationally.
 */
`timescale 1ns/1ns
`include "status_responder_defs.vh"
`default_nettype none
module axil_slave (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         wr_stb,
  output reg  [7:0]  wr_addr,
  output reg  [31:0] wr_data,
  output reg  [3:0]  wr_strb,
  input  wire        wr_ok,
  output wire        rd_stb,
  output wire [7:0]  rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);
  reg aw_have_q; // write address held
  reg w_have_q;  // write data held

  // write channel: take address and data in any order, then strobe once
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      wr_stb        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
    end else begin
      wr_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // both held and no response pending: apply the write
      if (aw_have_q && w_have_q && !s_axi_bvalid && !wr_stb) begin
        wr_stb <= 1'b1;
      end
      // response one cycle after the strobe
      if (wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign rd_stb  = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // read channel: data registered the cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (rd_stb) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> core/drive_status_query_responder.v
/*
 * command interpreter of a positioning drive's serial link: keeps the
 * motion status word, parses received frames and builds the answers.
 * assumes a byte receiver feeds frame bytes into a register and a byte
 * transmitter drains answer bytes from one, both behind axi4-lite.
 */
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "status_responder_defs.vh"
`default_nettype none
module drive_status_query_responder (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         motor_stop
);
  // bus strobes
  wire        wr_stb;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        rd_stb;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;
  reg         rd_ok;
  reg         wr_ok;
  // drive state
  reg [7:0]  ms_low_q;     // motion status low byte
  reg        jog_q;        // jog keys enabled
  reg        decel_q;      // drive decelerating
  reg [31:0] position_q;   // actual position
  reg [15:0] velocity_q;   // rpm times ten
  reg [7:0]  temp_q;       // degrees celsius
  reg [15:0] fault_q;      // drive fault word
  reg [7:0]  dev_addr_q;   // active address
  reg [7:0]  new_addr_q;   // pending address
  reg        rx_err_q;     // framing/parity/overrun seen in frame
  // frame reception
  reg [7:0]  rx_buf_q [0:7];   // first frame bytes
  reg [3:0]  rx_cnt_q;         // bytes received
  wire [7:0] rx_sum;
  // answer buffer
  reg [7:0]  tx_buf_q [0:15];  // answer bytes
  reg [4:0]  tx_len_q;         // answer length
  reg [4:0]  tx_rd_q;          // next byte to hand out
  reg [15:0] sci_err;          // transfer-error word of current frame
  integer    i;

  axil_slave bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_stb        (rd_stb),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // frame byte and end-of-frame writes
  wire rx_byte = wr_stb && (wr_addr == `REG_RX) && !wr_data[8] && wr_strb[0];
  wire rx_end  = wr_stb && (wr_addr == `REG_RX) && wr_data[8];
  wire tx_pop  = rd_stb && (rd_addr == `REG_TX);
  frame_checksum rx_check (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (rx_end),
    .add     (rx_byte),
    .data    (wr_data[7:0]),
    .sum     (rx_sum)
  );

  wire [7:0]  cmd     = rx_buf_q[1];
  wire [15:0] ms_word = {5'h00, decel_q, jog_q, 1'b0, ms_low_q};

  // expected frame length for a received command
  function [3:0] cmd_len;
    input [7:0] c;
    begin
      case (c)
        `CMD_VSET:            cmd_len = `FRAME_LEN_VSET;
        `CMD_PSET, `CMD_DSET: cmd_len = `FRAME_LEN_PSET;
        default:              cmd_len = `FRAME_LEN_PLAIN;
      endcase
    end
  endfunction

  // command is one this block understands
  function known_cmd;
    input [7:0] c;
    begin
      case (c)
        `CMD_GSTAT, `CMD_ERRSTAT, `CMD_STAT, `CMD_RESET, `CMD_START,
        `CMD_STOP, `CMD_VSET, `CMD_PSET, `CMD_DSET: known_cmd = 1'b1;
        default: known_cmd = 1'b0;
      endcase
    end
  endfunction

  // transfer-error word for the frame just closed
  always @* begin
    sci_err = 16'h0000;
    sci_err[`TE_FRAMING]  = rx_err_q;
    sci_err[`TE_CHECKSUM] = (rx_sum != 8'h00);
    sci_err[`TE_COUNT]    = (rx_cnt_q != cmd_len(cmd));
    sci_err[`TE_BADCMD]   = !known_cmd(cmd);
    sci_err[`TE_FAULT]    = (fault_q != 16'h0000);
  end

  wire frame_good = (sci_err[5:0] == 6'h00) && (sci_err[15:8] == 8'h00);
  wire for_us     = (rx_cnt_q != 4'd0) && (rx_buf_q[0] == dev_addr_q) && (rx_buf_q[0] != `ADDR_GLOBAL);
  // receive buffer and byte count
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_q <= 4'd0;
      rx_err_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        rx_buf_q[i] <= 8'h00;
      end
    end else if (rx_end) begin
      rx_cnt_q <= 4'd0;
      rx_err_q <= 1'b0;
    end else begin
      if (rx_byte) begin
        if (rx_cnt_q < 4'd8) begin
          rx_buf_q[rx_cnt_q[2:0]] <= wr_data[7:0];
        end
        if (rx_cnt_q != 4'hf) begin
          rx_cnt_q <= rx_cnt_q + 4'd1;
        end
      end
      // receiver reports line errors through the control register
      if (wr_stb && wr_addr == `REG_CTRL && wr_data[`CTRL_RX_ERR]) begin
        rx_err_q <= 1'b1; // clear at end-of-frame wins over set; only end-of-frame clears
      end
    end
  end

  // motion status, drive values and answer assembly
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_low_q   <= `MS_RESET;
      jog_q      <= 1'b0;
      decel_q    <= 1'b0;
      position_q <= 32'h00000000;
      velocity_q <= 16'h0000;
      temp_q     <= 8'h00;
      fault_q    <= 16'h0000;
      dev_addr_q <= `DEV_ADDR_RESET;
      new_addr_q <= `DEV_ADDR_RESET;
      motor_stop <= 1'b0;
      tx_len_q   <= 5'd0;
      tx_rd_q    <= 5'd0;
    end else begin
      motor_stop <= 1'b0;
      ms_low_q[`MS_ALWAYS_ONE] <= 1'b1;
      ms_low_q[`MS_RSVD0] <= 1'b0;
      ms_low_q[`MS_RSVD3] <= 1'b0;
      // software-visible drive values
      if (wr_stb) begin
        case (wr_addr)
          `REG_CTRL: begin
            decel_q <= wr_data[`CTRL_DECEL];
            jog_q   <= wr_data[`CTRL_JOG];
            if (wr_data[`CTRL_END_REACHED]) begin
              ms_low_q[`MS_NOT_AT_END] <= 1'b0;
              ms_low_q[`MS_POS_RUN]    <= 1'b0;
            end
          end
          `REG_POSITION: position_q <= wr_data;
          `REG_VEL_TEMP: begin
            velocity_q <= wr_data[15:0];
            temp_q     <= wr_data[23:16];
          end
          `REG_FAULT: fault_q <= fault_q | wr_data[15:0];
          `REG_DEV_ADDR: new_addr_q <= wr_data[7:0];
          default: ;
        endcase
      end
      if (tx_pop && tx_rd_q < tx_len_q) begin
        tx_rd_q <= tx_rd_q + 5'd1;
      end
      // close of a frame addressed to this drive
      if (rx_end && for_us) begin
        if (frame_good) begin
          case (cmd)
            `CMD_VSET: ms_low_q[`MS_VEL_READY] <= 1'b0;
            `CMD_PSET, `CMD_DSET: ms_low_q[`MS_POS_READY] <= 1'b0;
            `CMD_START: begin
              ms_low_q[`MS_VEL_READY] <= 1'b1;
              ms_low_q[`MS_POS_READY] <= 1'b1;
              ms_low_q[`MS_NOT_AT_END] <= 1'b1;
              if (!ms_low_q[`MS_VEL_READY]) begin
                ms_low_q[`MS_VEL_RUN] <= 1'b1;
              end else if (!ms_low_q[`MS_POS_READY]) begin
                ms_low_q[`MS_POS_RUN] <= 1'b1;
              end
            end
            `CMD_STOP: begin
              ms_low_q[`MS_VEL_RUN] <= 1'b0;
              ms_low_q[`MS_POS_RUN] <= 1'b0;
              motor_stop <= 1'b1;
            end
            `CMD_RESET: begin
              ms_low_q[`MS_VEL_RUN] <= 1'b0;
              ms_low_q[`MS_POS_RUN] <= 1'b0;
              motor_stop <= 1'b1;
              fault_q    <= 16'h0000;
              dev_addr_q <= new_addr_q;
            end
            default: ;
          endcase
        end
        // header: address, echoed command, transfer-error high then low
        tx_buf_q[0] <= rx_buf_q[0];
        tx_buf_q[1] <= cmd;
        tx_buf_q[2] <= sci_err[15:8];
        tx_buf_q[3] <= sci_err[7:0];
        tx_len_q <= `LEN_PLAIN;
        if (frame_good && (cmd == `CMD_GSTAT || cmd == `CMD_STAT)) begin
          tx_buf_q[4]  <= ms_word[15:8];
          tx_buf_q[5]  <= ms_word[7:0];
          tx_buf_q[6]  <= position_q[31:24];
          tx_buf_q[7]  <= position_q[23:16];
          tx_buf_q[8]  <= position_q[15:8];
          tx_buf_q[9]  <= position_q[7:0];
          tx_buf_q[10] <= velocity_q[15:8];
          tx_buf_q[11] <= velocity_q[7:0];
          tx_buf_q[12] <= temp_q;
          tx_buf_q[13] <= fault_q[15:8];
          tx_buf_q[14] <= fault_q[7:0];
          tx_len_q <= (cmd == `CMD_GSTAT) ? `LEN_GSTAT : `LEN_STAT;
        end else if (frame_good && cmd == `CMD_ERRSTAT) begin
          tx_buf_q[4] <= fault_q[15:8];
          tx_buf_q[5] <= fault_q[7:0];
          tx_len_q <= `LEN_ERRSTAT;
        end
        tx_rd_q  <= 5'd0;
      end else if (rx_end) begin
        tx_len_q <= 5'd0;
        tx_rd_q  <= 5'd0;
      end
    end
  end

  // checksum over bytes before the last one
  function [7:0] tx_sum;
    input [4:0] n;
    integer k;
    begin
      tx_sum = 8'h00;
      for (k = 0; k < 15; k = k + 1) begin
        if (k < n - 1) begin
          tx_sum = tx_sum ^ tx_buf_q[k];
        end
      end
    end
  endfunction

  // register read mux; tx register hands out next answer byte
  always @* begin
    rd_ok = 1'b1;
    wr_ok = (wr_addr <= `REG_RX) && (wr_addr[1:0] == 2'b00) && (wr_addr != `REG_STATUS);
    case (rd_addr)
      `REG_CTRL:     rd_data = {28'h0000000, 1'b0, jog_q, decel_q, 1'b0};
      `REG_STATUS:   rd_data = {16'h0000, ms_word};
      `REG_POSITION: rd_data = position_q;
      `REG_VEL_TEMP: rd_data = {8'h00, temp_q, velocity_q};
      `REG_FAULT:    rd_data = {16'h0000, fault_q};
      `REG_DEV_ADDR: rd_data = {16'h0000, new_addr_q, dev_addr_q};
      `REG_RX:       rd_data = {28'h0000000, rx_cnt_q};
      `REG_TX: begin
        if (tx_rd_q < tx_len_q) begin
          rd_data = {23'h000000, 1'b1,
                     (tx_rd_q == tx_len_q - 5'd1) ? tx_sum(tx_len_q) : tx_buf_q[tx_rd_q[3:0]]};
        end else begin
          rd_data = 32'h00000000;
        end
      end
      default: begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/drive_status_query_responder_sva.sv
/*
 * concurrent checks on the axi4-lite handshakes and the stop pulse.
 * assumes it is bound to the responder top with a synchronous aresetn.
 */
`timescale 1ns/1ns
`default_nettype none
module status_responder_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        motor_stop
);
  // every check samples on the rising clock and rests during reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not free after handshake");
  AST_WR_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> (!s_axi_bvalid) [*2] ##1 s_axi_bvalid)
    else $error("write response not on third edge after take");
  AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not free after handshake");
  AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_RD_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  AST_STOP_PULSE: assert property ($rose(motor_stop) |=> !motor_stop)
    else $error("stop pulse longer than one cycle");
  AST_WR_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("illegal write response code");
endmodule

bind drive_status_query_responder status_responder_checker status_responder_checker_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .motor_stop
);
`default_nettype wire

// >>> tb/bus_master.sv
/*
 * host side model: axi4-lite master issuing one transfer at a time.
 * assumes tasks are called right after a rising edge, one after another.
 */
`timescale 1ns/1ns
`default_nettype none
module bus_master (
  input  wire logic        aclk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  logic [31:0] rdat; // data of the last read
  logic [1:0]  rsp;  // response code of the last transfer

  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  // register write, response code kept in rsp
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // register read, data taken at the handshake edge
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> tb/drive_status_query_responder_test.sv
/*
 * self-checking bench: frames pushed and answers drained over axi4-lite.
 * assumes the defs header is on the include path.
 */
`timescale 1ns/1ns
`include "status_responder_defs.vh"
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module drive_status_query_responder_test;
  logic        aclk, aresetn, motor_stop;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0; // mismatches
  int          checked = 0;   // comparisons
  int          stop_cnt = 0;  // stop pulses seen on motor_stop

  drive_status_query_responder drive_status_query_responder_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_stop
  );
  bus_master bus_master_i (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // 100 mhz clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // count stop pulses; an unknown level counts none
  always @(posedge aclk) if (motor_stop === 1'b1) stop_cnt++;

  // push n bytes, then xor checksum spoilt by bad, then close
  task push(input logic [127:0] v, input int n, input logic [7:0] bad);
    logic [7:0] ck;
    ck = bad;
    for (int i = n - 1; i >= 0; i--) begin
      ck ^= v[8*i+:8];
      bus_master_i.wr(`REG_RX, {24'h0, v[8*i+:8]});
    end
    bus_master_i.wr(`REG_RX, {24'h0, ck});
    bus_master_i.wr(`REG_RX, 32'h100);
  endtask

  // drain answer bytes, checksum, then expect empty
  task answer(input logic [127:0] v, input int n);
    logic [7:0] ck;
    ck = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      ck ^= v[8*i+:8];
      bus_master_i.rd(`REG_TX);
      `CHK(bus_master_i.rdat[8:0], {1'b1, v[8*i+:8]})
    end
    bus_master_i.rd(`REG_TX);
    `CHK(bus_master_i.rdat[8:0], {1'b1, ck})
    bus_master_i.rd(`REG_TX);
    `CHK(bus_master_i.rdat, 32'h0)
  endtask

  // clean frame and its answer
  task cmd(input logic [127:0] f, input int fn, input logic [127:0] a, input int an);
    push(f, fn, 8'h00);
    answer(a, an);
  endtask

  // masked motion status compare
  task stat(input logic [15:0] e, input logic [15:0] m);
    bus_master_i.rd(`REG_STATUS);
    `CHK(bus_master_i.rdat[15:0] & m, e)
  endtask

  // end of run with counts and verdict
  task end_of_test;
    $display("errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    end_of_test;
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    stat(16'h0016, 16'hffff);
    bus_master_i.wr(`REG_POSITION, 32'h0002_0000);
    bus_master_i.wr(`REG_VEL_TEMP, 32'h0022_0000);
    cmd(16'h0110, 2, 120'h011000000016000200000000220000, 15);
    bus_master_i.wr(`REG_VEL_TEMP, 32'h0022_01f4);
    cmd(16'h0112, 2, 104'h0112000000160002000001f422, 13);
    cmd(16'h0111, 2, 48'h011100000000, 6);
    push(16'hff12, 2, 8'h00);
    bus_master_i.rd(`REG_TX);
    `CHK(bus_master_i.rdat, 32'h0)
    push(16'h0112, 2, 8'h5a);
    answer(32'h01120004, 4);
    cmd(24'h011255, 3, 32'h01120010, 4);
    cmd(16'h0155, 2, 32'h01550200, 4);
    bus_master_i.wr(`REG_CTRL, 32'h8);
    cmd(16'h0112, 2, 32'h01120001, 4);
    cmd(64'h0143000000103200, 8, 32'h01430000, 4);
    stat(16'h0012, 16'hffff);
    cmd(16'h0131, 2, 32'h01310000, 4);
    stat(16'h00b6, 16'hffff);
    bus_master_i.wr(`REG_CTRL, 32'h1);
    stat(16'h0016, 16'hffff);
    bus_master_i.wr(`REG_CTRL, 32'h6);
    stat(16'h0616, 16'hffff);
    bus_master_i.wr(`REG_CTRL, 32'h0);
    cmd(48'h014101640099, 6, 32'h01410000, 4);
    stat(16'h0014, 16'hffff);
    cmd(16'h0131, 2, 32'h01310000, 4);
    stat(16'h0056, 16'hffdf);
    cmd(16'h0132, 2, 32'h01320000, 4);
    bus_master_i.wr(`REG_FAULT, 32'h1);
    cmd(16'h0111, 2, 48'h011100400001, 6);
    bus_master_i.wr(`REG_DEV_ADDR, 32'h5);
    `CHK(bus_master_i.rsp, `AXI_OKAY)
    push(16'h0121, 2, 8'h00);
    answer(32'h01210040, 4);
    `CHK(stop_cnt, 2)
    cmd(16'h0511, 2, 48'h051100000000, 6);
    bus_master_i.rd(8'h20);
    `CHK(bus_master_i.rsp, `AXI_SLVERR)
    `CHK(bus_master_i.rdat, 32'h0)
    bus_master_i.wr(`REG_STATUS, 32'h0);
    `CHK(bus_master_i.rsp, `AXI_SLVERR)
    stat(16'h0016, 16'hffdf);
    end_of_test;
  end
endmodule
`default_nettype wire
